// File: hdl/asbi_consts.vh
// constants for the serial result port with busy indicator
`ifndef ASBI_CONSTS_VH
`define ASBI_CONSTS_VH
`define ASBI_CFG_W 14
`define ASBI_RES_W 16
`define ASBI_CFG_RST 14'h3fff
`define ASBI_RB_BIT 0
`define ASBI_RES_LAST 16
`define ASBI_RES_REL 17
`define ASBI_CFG_LAST 30
`define ASBI_CFG_REL 31
`define ASBI_CONV_NS 1600
`define ASBI_CLK_MHZ 200
`define ASBI_CONV_CYC ((`ASBI_CONV_NS * `ASBI_CLK_MHZ) / 1000)
`endif

// File: hdl/asbi_port.v
// serial conversion port with busy indicator, device side
`timescale 1ns/10ps
`include "asbi_consts.vh"
module asbi_port #(
  parameter CONV_CYC = `ASBI_CONV_CYC
) (
  input wire core_clk_i,
  input wire nrst_i,
  input wire convert_start_i,
  input wire sclk_i,
  input wire sdi_i,
  input wire [`ASBI_RES_W-1:0] conv_result_i,
  output reg serial_result_out_o,
  output reg serial_result_out_oe_o,
  output reg converting_o,
  output reg core_power_o,
  output reg conv_done_o,
  output reg [`ASBI_CFG_W-1:0] cfg_o
);
  // ****************************************
  // local constants and state codes
  // ****************************************
  localparam SHIFT_W = `ASBI_RES_W + `ASBI_CFG_W;
  localparam N_PINS = 3;
  localparam [N_PINS-1:0] PIN_IDLE = 3'h2;
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_CONV = 3'h2;
  localparam [2:0] ST_XFER = 3'h4;
  localparam [4:0] CFG_FULL = `ASBI_CFG_W;
  localparam [5:0] SHIFT_LAST_CNT = `ASBI_CFG_LAST;
  localparam [5:0] RES_REL_CNT = `ASBI_RES_REL - 1;
  localparam [5:0] CFG_REL_CNT = `ASBI_CFG_REL - 1;
  localparam [31:0] CONV_LOAD = CONV_CYC;

  // ****************************************
  // state and datapath registers
  // ****************************************
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [31:0] conv_cnt_reg;
  reg [31:0] conv_cnt_next;
  reg [`ASBI_CFG_W-1:0] cfg_reg;
  reg [`ASBI_CFG_W-1:0] cfg_next;
  reg [`ASBI_CFG_W-1:0] cfg_sh_reg;
  reg [`ASBI_CFG_W-1:0] cfg_sh_next;
  reg [4:0] cfg_cnt_reg;
  reg [4:0] cfg_cnt_next;
  reg [SHIFT_W-1:0] out_sh_reg;
  reg [SHIFT_W-1:0] out_sh_next;
  reg [5:0] fall_cnt_reg;
  reg [5:0] fall_cnt_next;
  reg sdo_next;
  reg sdo_oe_next;
  reg cnv_d_reg;
  reg sck_d_reg;

  // ****************************************
  // input synchronisers
  // ****************************************
  wire [N_PINS-1:0] pin_raw;
  wire [N_PINS-1:0] pin_sync;
  assign pin_raw = {sdi_i, sclk_i, convert_start_i};
  genvar g;
  generate
    for (g = 0; g < N_PINS; g = g + 1) begin : g_sync
      // two flops per pin, only the second is read
      reg meta_reg;
      reg sync_reg;
      always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          meta_reg <= PIN_IDLE[g];
          sync_reg <= PIN_IDLE[g];
        end else begin
          meta_reg <= pin_raw[g];
          sync_reg <= meta_reg;
        end
      end
      assign pin_sync[g] = sync_reg;
    end
  endgenerate
  wire cnv_s = pin_sync[0];
  wire sck_s = pin_sync[1];
  wire sdi_s = pin_sync[2];

  // ****************************************
  // edge detection
  // ****************************************
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnv_d_reg <= 1'b0;
      sck_d_reg <= 1'b1; // idles high, so no false edge after reset
    end else begin
      cnv_d_reg <= cnv_s;
      sck_d_reg <= sck_s;
    end
  end
  wire cnv_rise = cnv_s & ~cnv_d_reg;
  wire sck_rise = sck_s & ~sck_d_reg;
  wire sck_fall = ~sck_s & sck_d_reg;

  // ****************************************
  // decoded conditions
  // ****************************************
  wire st_conv = state_reg[1];
  wire st_xfer = state_reg[2];
  wire start = cnv_rise && !st_conv;
  wire eoc = st_conv && (conv_cnt_reg == 32'h1);
  wire rb_on = ~cfg_reg[`ASBI_RB_BIT];
  wire xfer_act = st_xfer && !cnv_s;
  wire cfg_take = xfer_act && sck_rise && (cfg_cnt_reg < CFG_FULL);
  wire out_step = xfer_act && sck_fall;
  wire rel_res = out_step && !rb_on && (fall_cnt_reg == RES_REL_CNT);
  wire rel_cfg = out_step && rb_on && (fall_cnt_reg == CFG_REL_CNT);
  wire release_now = rel_res || rel_cfg;

  // ****************************************
  // state machine
  // ****************************************
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start)
          state_next = ST_CONV;
      end
      ST_CONV: begin
        if (eoc && !cnv_s)
          state_next = ST_XFER;
        else if (eoc)
          state_next = ST_IDLE;
      end
      ST_XFER: begin
        if (start)
          state_next = ST_CONV;
        else if (release_now)
          state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // conversion timer
  // ****************************************
  always @* begin
    conv_cnt_next = conv_cnt_reg;
    if (start)
      conv_cnt_next = CONV_LOAD;
    else if (st_conv)
      conv_cnt_next = conv_cnt_reg - 32'h1;
  end

  // ****************************************
  // config shift-in
  // ****************************************
  always @* begin
    cfg_next = cfg_reg;
    cfg_sh_next = cfg_sh_reg;
    cfg_cnt_next = cfg_cnt_reg;
    if (eoc) begin
      // a partial word never reaches the live configuration
      if (cfg_cnt_reg == CFG_FULL)
        cfg_next = cfg_sh_reg;
      cfg_cnt_next = 5'h0;
    end else if (cfg_take) begin
      cfg_sh_next = {cfg_sh_reg[`ASBI_CFG_W-2:0], sdi_s};
      cfg_cnt_next = cfg_cnt_reg + 5'h1;
    end
  end

  // ****************************************
  // result shifter and pin driver
  // ****************************************
  always @* begin
    out_sh_next = out_sh_reg;
    fall_cnt_next = fall_cnt_reg;
    sdo_next = serial_result_out_o;
    sdo_oe_next = serial_result_out_oe_o;
    if (start) begin
      sdo_oe_next = 1'b0;
    end else if (eoc) begin
      // old result is overwritten here, unread bits are lost
      out_sh_next = {conv_result_i, cfg_reg};
      fall_cnt_next = 6'h0;
      if (!cnv_s) begin
        sdo_next = 1'b0;
        sdo_oe_next = 1'b1;
      end else begin
        sdo_oe_next = 1'b0;
      end
    end else if (out_step) begin
      fall_cnt_next = fall_cnt_reg + 6'h1;
      if (fall_cnt_reg < SHIFT_LAST_CNT) begin
        sdo_next = out_sh_reg[SHIFT_W-1];
        out_sh_next = {out_sh_reg[SHIFT_W-2:0], 1'b0};
      end
      if (rel_res)
        sdo_oe_next = 1'b0;
      if (rel_cfg)
        sdo_oe_next = 1'b0;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // ****************************************
  // timer register
  // ****************************************
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i)
      conv_cnt_reg <= 32'h0;
    else
      conv_cnt_reg <= conv_cnt_next;
  end

  // ****************************************
  // config registers
  // ****************************************
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_reg <= `ASBI_CFG_RST;
      cfg_sh_reg <= 14'h0;
      cfg_cnt_reg <= 5'h0;
    end else begin
      cfg_reg <= cfg_next;
      cfg_sh_reg <= cfg_sh_next;
      cfg_cnt_reg <= cfg_cnt_next;
    end
  end

  // ****************************************
  // shifter registers
  // ****************************************
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out_sh_reg <= {SHIFT_W{1'b0}};
      fall_cnt_reg <= 6'h0;
    end else begin
      out_sh_reg <= out_sh_next;
      fall_cnt_reg <= fall_cnt_next;
    end
  end

  // ****************************************
  // pin driver registers
  // ****************************************
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      serial_result_out_o <= 1'b0;
      serial_result_out_oe_o <= 1'b0;
    end else begin
      serial_result_out_o <= sdo_next;
      serial_result_out_oe_o <= sdo_oe_next;
    end
  end

  // ****************************************
  // conversion status outputs
  // ****************************************
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      converting_o <= 1'b0;
      core_power_o <= 1'b0;
      conv_done_o <= 1'b0;
    end else begin
      converting_o <= st_conv;
      core_power_o <= st_conv;
      conv_done_o <= eoc;
    end
  end

  // ****************************************
  // configuration output
  // ****************************************
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i)
      cfg_o <= `ASBI_CFG_RST;
    else
      cfg_o <= cfg_reg;
  end
endmodule // asbi_port

// File: dv/asbi_port_properties.sv
// checker for the serial result port
`timescale 1ns/10ps
`include "asbi_consts.vh"
module asbi_props #(parameter CONV_CYC = 20) (
  input wire core_clk_i, input wire nrst_i, input wire convert_start_i, input wire sclk_i,
  input wire serial_result_out_o, input wire serial_result_out_oe_o, input wire converting_o,
  input wire core_power_o, input wire conv_done_o, input wire [`ASBI_CFG_W-1:0] cfg_o);
  localparam int LO = CONV_CYC - 2;
  localparam int HI = CONV_CYC + 2;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  // ***
  // properties
  // ***
  chk_float_start: assert property ($rose(converting_o) |=> !serial_result_out_oe_o) else $error("float");
  chk_runs_on: assert property ($rose(converting_o) |-> converting_o[*8]) else $error("cut short");
  chk_conv_time: assert property ($rose(converting_o) |-> ##[LO:HI] conv_done_o) else $error("length");
  chk_busy_low: assert property (conv_done_o && !convert_start_i |=> serial_result_out_oe_o &&
    !serial_result_out_o) else $error("no busy");
  chk_power_off: assert property (conv_done_o |=> !core_power_o [*2]) else $error("power");
  chk_no_busy: assert property (conv_done_o && convert_start_i |=> !serial_result_out_oe_o)
    else $error("busy");
  chk_cfg_apply: assert property ($changed(cfg_o) |-> conv_done_o || $past(conv_done_o))
    else $error("cfg");
  chk_data_edge: assert property (serial_result_out_oe_o && $past(serial_result_out_oe_o) &&
    !$past(conv_done_o) && $changed(serial_result_out_o) |-> !sclk_i) else $error("data");
  cover property (conv_done_o && !convert_start_i);
  cover property (conv_done_o && convert_start_i);
  cover property ($fell(serial_result_out_oe_o));
endmodule // asbi_props
bind asbi_port asbi_props #(.CONV_CYC(CONV_CYC)) u_props (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
  .convert_start_i(convert_start_i), .sclk_i(sclk_i), .serial_result_out_o(serial_result_out_o),
  .serial_result_out_oe_o(serial_result_out_oe_o), .converting_o(converting_o), .core_power_o(core_power_o),
  .conv_done_o(conv_done_o), .cfg_o(cfg_o));

// File: dv/asbi_host.sv
// host controller model with pull-up
`timescale 1ns/10ps
module asbi_host (
  input wire core_clk_i, input wire sdo_i, input wire sdo_oe_i,
  output logic cnv_o, output logic sclk_o, output logic sdi_o, output wire line_o);
  // ***
  // host
  // ***
  assign line_o = sdo_oe_i ? sdo_i : 1'b1;
  initial cnv_o = 1'b0;
  initial sclk_o = 1'b1;
  initial sdi_o = 1'b0;
  task automatic gap(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  task automatic start(input logic hi, input int cyc);
    cnv_o = 1'b1;
    gap(6);
    cnv_o = 1'b0;
    gap(4);
    cnv_o = 1'b1;
    gap(4);
    cnv_o = hi;
    gap(cyc + 12);
    cnv_o = 1'b0;
  endtask
  task automatic xfer(input logic [13:0] cfg, input int n, output logic [30:0] rd);
    rd = '0;
    sdi_o = cfg[13];
    for (int i = 0; i < n; i++) begin
      sclk_o = 1'b0;
      sdi_o = i < 14 ? cfg[13-i] : ~sdi_o;
      gap(16);
      sclk_o = 1'b1;
      rd = {rd[29:0], line_o};
      gap(16);
    end
  endtask
endmodule // asbi_host

// File: dv/testbench.sv
// self-checking bench for the serial result port
`timescale 1ns/10ps
module testbench;
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [15:0] conv_result_i = 16'h0000;
  wire convert_start_i, sclk_i, sdi_i, serial_result_out_o, serial_result_out_oe_o, ln, pw, dn, cv;
  wire [13:0] cfg;
  logic [30:0] rd;
  int n_fail = 0;
  int compares = 0;
  int n_done = 0;
  always #2.5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) if (dn) n_done++;
  asbi_port #(.CONV_CYC(20)) DUT (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .convert_start_i(convert_start_i),
    .sclk_i(sclk_i), .sdi_i(sdi_i), .conv_result_i(conv_result_i), .serial_result_out_o(serial_result_out_o),
    .serial_result_out_oe_o(serial_result_out_oe_o), .converting_o(cv), .core_power_o(pw), .conv_done_o(dn),
    .cfg_o(cfg));
  asbi_host host (.core_clk_i(core_clk_i), .sdo_i(serial_result_out_o), .sdo_oe_i(serial_result_out_oe_o),
    .cnv_o(convert_start_i), .sclk_o(sclk_i), .sdi_o(sdi_i), .line_o(ln));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ***
  // scenarios
  // ***
  task automatic t_plain;
    conv_result_i = 16'ha5c3;
    host.start(1'b0, 20);
    check({serial_result_out_oe_o, ln, pw, cv}, 4'b1000);
    host.xfer(14'h3ffe, 17, rd);
    check(rd[16:0], {16'ha5c3, 1'b1});
    check(cfg, 14'h3fff);
  endtask
  task automatic t_rb;
    conv_result_i = 16'h1234;
    host.start(1'b0, 20);
    check(cfg, 14'h3ffe);
    host.xfer(14'h3ffe, 31, rd);
    check(rd, {16'h1234, 14'h3fff, 1'b1});
  endtask
  task automatic t_part;
    conv_result_i = 16'h8001;
    host.start(1'b0, 20);
    host.xfer(14'h0001, 8, rd);
    check({serial_result_out_oe_o, ln, rd[7:0]}, 10'h280);
    conv_result_i = 16'h7777;
    host.start(1'b0, 20);
    check(cfg, 14'h3ffe);
    host.xfer(14'h3ffe, 31, rd);
    check(rd[30:15], 16'h7777);
  endtask
  task automatic t_nobusy;
    host.start(1'b1, 20);
    check({serial_result_out_oe_o, ln}, 2'b01);
  endtask
  initial begin
    repeat (5) @(negedge core_clk_i);
    nrst_i = 1'b1;
    check(cfg, 14'h3fff);
    repeat (3) @(negedge core_clk_i);
    t_plain();
    t_rb();
    t_part();
    t_nobusy();
    check(n_done, 5);
    results();
  end
  initial begin
    #60000;
    n_fail++;
    results();
  end
endmodule // testbench
